// ===== rtl/flash_host.v
`timescale 1ns/1ps
`include "flash_host_regs.vh"
// Summary of operation
// [RL1] device latches commands internally; host only writes bus cycles, no map address
// [RL2] read: chip select low, output enable low, write strobe held high
// [RL3] after reset pulse host assumes array read, reads need no command
// [RL4] array read persists until host writes a command
// [RL5] page is address above bit 1; bits 1..0 pick the word
// [RL6] first page access waits full time; same-page reads wait short time
// [RL7] write: write strobe and chip select low, output enable high
// [RL8] accelerated/bypass program issues two write cycles instead of four
// [RL9] erase of sector, sectors or chip is a raw write sequence
// [RL10] buffered programming limited to 16 words per operation
// [RL11] raising protect pin boost puts device in two-cycle mode
// [RL12] dropping boost returns device to normal operation
// [RL13] boost applied only during accelerated program, with two-cycle sequences
// [RL14] protect pin driven low keeps boot sector protected
// [RL15] sectors arrive unprotected; host assumes nothing further
// [RL16] autoselect sequence then normal reads return low-byte codes
// [RL17] host drives all 22 word address bits
// [RL18] reset pin held low at least the reset pulse time
// [RL19] deselect during program is allowed; device finishes on its own
// [RL20] host drives data bus only during write cycles
// [RL21] each write cycle is one qualified strobe, one state machine step
module flash_host #(
  parameter ADDR_W = `ADDR_W,
  parameter DATA_W = `DATA_W
) (
  // clock and reset
  input  wire              core_clk_i,
  input  wire              nrst_i,
  // user request
  input  wire              req_valid_i,
  input  wire [2:0]        req_op_i,
  input  wire [ADDR_W-1:0] req_addr_i,
  input  wire [DATA_W-1:0] req_data_i,
  input  wire              accel_i,
  input  wire              protect_i,
  output wire              req_ready_o,
  output reg               rsp_valid_o,
  output reg  [DATA_W-1:0] rsp_data_o,
  // flash pins
  output reg  [ADDR_W-1:0] flash_addr_o,
  output reg               flash_ce_n_o,
  output reg               flash_oe_n_o,
  output reg               flash_we_n_o,
  output reg               flash_reset_n_o,
  output reg               protect_accel_pin_o,
  output reg               program_boost_level_o,
  input  wire [DATA_W-1:0] flash_dq_i,
  output reg  [DATA_W-1:0] flash_dq_o,
  output reg               flash_dq_oe_o
);
  localparam [5:0] S_IDLE = 6'b00_0001;
  localparam [5:0] S_READ = 6'b00_0010;
  localparam [5:0] S_WLOW = 6'b00_0100;
  localparam [5:0] S_WREC = 6'b00_1000;
  localparam [5:0] S_RST  = 6'b01_0000;
  localparam [5:0] S_RREC = 6'b10_0000;
  // counts are worked out as integers, then cut to the counter width on purpose
  localparam integer RACC_N = `RANDOM_ACCESS_CYC;
  localparam integer PACC_N = `IN_PAGE_ACCESS_CYC;
  localparam integer WP_N   = `WRITE_PULSE_CYC;
  localparam integer WR_N   = `WRITE_RECOVER_CYC;
  localparam integer RP_N   = `RESET_PULSE_CYC;
  localparam integer RR_N   = `RESET_RECOVER_CYC;
  localparam [7:0] C_RACC = RACC_N[7:0];
  localparam [7:0] C_PACC = PACC_N[7:0];
  localparam [7:0] C_WP   = WP_N[7:0];
  localparam [7:0] C_WR   = WR_N[7:0];
  localparam [7:0] C_RP   = RP_N[7:0];
  localparam [7:0] C_RR   = RR_N[7:0];

  reg [5:0]        state_ff;
  reg [7:0]        cnt_ff;
  reg [2:0]        step_ff;
  reg [2:0]        nsteps_ff;
  reg [2:0]        op_ff;
  reg [ADDR_W-1:0] addr_ff;
  reg [DATA_W-1:0] data_ff;
  reg              page_ok_ff;
  reg [ADDR_W-1:`PAGE_LSB] page_ff;
  reg              auto_ff;

  // word sequence of each command, unlock cycles first
  function [ADDR_W+DATA_W-1:0] seq_word;
    input [2:0]        op;
    input [2:0]        idx;
    input              bypass;
    input [ADDR_W-1:0] a;
    input [DATA_W-1:0] d;
    reg   [2:0]        k;
    begin
      k = bypass ? idx + 3'd2 : idx;
      case (k)
        3'd0:    seq_word = {`CMD_ADDR_UNLOCK1, `CMD_DATA_UNLOCK1};
        3'd1:    seq_word = {`CMD_ADDR_UNLOCK2, `CMD_DATA_UNLOCK2};
        3'd2:    seq_word = {`CMD_ADDR_UNLOCK1, (op == `OP_PROGRAM) ? `CMD_DATA_PROGRAM :
                             (op == `OP_AUTOSEL) ? `CMD_DATA_AUTOSEL : `CMD_DATA_RESET};
        default: seq_word = {a, d};
      endcase
    end
  endfunction

  assign req_ready_o = (state_ff == S_IDLE);
  wire [ADDR_W+DATA_W-1:0] cur_word = seq_word(op_ff, step_ff, accel_i, addr_ff, data_ff);
  wire same_page = page_ok_ff && (req_addr_i[ADDR_W-1:`PAGE_LSB] == page_ff); // RL5

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      step_ff <= 3'h0;
      nsteps_ff <= 3'h0;
      op_ff <= `OP_READ;
      addr_ff <= {ADDR_W{1'b0}};
      data_ff <= {DATA_W{1'b0}};
      page_ok_ff <= 1'b0;
      page_ff <= {(ADDR_W-`PAGE_LSB){1'b0}};
      auto_ff <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= {DATA_W{1'b0}};
      flash_addr_o <= {ADDR_W{1'b0}};
      flash_ce_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1;
      flash_we_n_o <= 1'b1;
      flash_reset_n_o <= 1'b1;
      protect_accel_pin_o <= 1'b0;
      program_boost_level_o <= 1'b0;
      flash_dq_o <= {DATA_W{1'b0}};
      flash_dq_oe_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      // no protection state is assumed beyond what this pin sets
      protect_accel_pin_o <= accel_i | protect_i; // RL14 RL15
      // boost only while an accelerated program is on the bus
      program_boost_level_o <= accel_i && (state_ff != S_IDLE) &&
                               (op_ff == `OP_PROGRAM); // RL11 RL12
      case (state_ff)
        S_IDLE: begin
          flash_dq_oe_o <= 1'b0;
          if (req_valid_i) begin
            op_ff <= req_op_i;
            addr_ff <= req_addr_i;
            data_ff <= req_data_i;
            step_ff <= 3'h0;
            case (req_op_i)
              `OP_READ: begin
                flash_addr_o <= req_addr_i; // RL17
                flash_ce_n_o <= 1'b0; // RL2
                flash_oe_n_o <= 1'b0;
                flash_we_n_o <= 1'b1;
                cnt_ff <= same_page ? C_PACC : C_RACC; // RL6
                page_ff <= req_addr_i[ADDR_W-1:`PAGE_LSB];
                page_ok_ff <= 1'b1;
                state_ff <= S_READ;
              end
              `OP_RESET: begin
                flash_reset_n_o <= 1'b0; // RL18
                flash_ce_n_o <= 1'b1;
                page_ok_ff <= 1'b0;
                cnt_ff <= C_RP;
                state_ff <= S_RST;
              end
              default: begin
                // accelerated program skips the two unlock cycles
                nsteps_ff <= (req_op_i == `OP_WRITE) ? 3'd1 :
                             (req_op_i == `OP_EXIT) ? 3'd3 :
                             (accel_i && req_op_i == `OP_PROGRAM) ? 3'd2 :
                             (req_op_i == `OP_PROGRAM) ? 3'd4 : 3'd3; // RL8
                page_ok_ff <= 1'b0;
                cnt_ff <= 8'h00;
                state_ff <= S_WREC;
              end
            endcase
          end
        end
        S_READ: begin
          if (cnt_ff <= 8'h01) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= auto_ff ? {{(DATA_W-8){1'b0}}, flash_dq_i[7:0]} : flash_dq_i; // RL16
            flash_oe_n_o <= 1'b1;
            // chip select stays low so the next read can hit the open page
            state_ff <= S_IDLE;
          end else
            cnt_ff <= cnt_ff - 8'h01;
        end
        S_WLOW: begin
          if (cnt_ff <= 8'h01) begin
            flash_we_n_o <= 1'b1; // RL21
            step_ff <= step_ff + 3'h1;
            cnt_ff <= C_WR;
            state_ff <= S_WREC;
          end else
            cnt_ff <= cnt_ff - 8'h01;
        end
        S_WREC: begin
          if (cnt_ff > 8'h01)
            cnt_ff <= cnt_ff - 8'h01;
          else if (step_ff == nsteps_ff) begin
            flash_dq_oe_o <= 1'b0; // RL20
            flash_ce_n_o <= 1'b1; // RL19
            // drop boost as the last write ends, not a cycle later
            program_boost_level_o <= 1'b0; // RL12
            if (op_ff == `OP_AUTOSEL)
              auto_ff <= 1'b1;
            else if (op_ff == `OP_EXIT)
              auto_ff <= 1'b0; // RL4
            // a lone reset command written raw also leaves code mode
            else if (op_ff == `OP_WRITE && data_ff == `CMD_DATA_RESET)
              auto_ff <= 1'b0; // RL4
            state_ff <= S_IDLE;
          end else begin
            // raw writes carry erase and buffer sequences word by word
            if (op_ff == `OP_WRITE)
              {flash_addr_o, flash_dq_o} <= {addr_ff, data_ff}; // RL9 RL10
            else if (op_ff == `OP_EXIT)
              {flash_addr_o, flash_dq_o} <= seq_word(`OP_RESET, step_ff, 1'b0, addr_ff, data_ff);
            else
              {flash_addr_o, flash_dq_o} <= cur_word; // RL1
            flash_ce_n_o <= 1'b0; // RL7
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b0;
            flash_dq_oe_o <= 1'b1; // RL20
            cnt_ff <= C_WP;
            state_ff <= S_WLOW;
          end
        end
        S_RST: begin
          if (cnt_ff <= 8'h01) begin
            flash_reset_n_o <= 1'b1;
            auto_ff <= 1'b0; // RL3
            cnt_ff <= C_RR;
            state_ff <= S_RREC;
          end else
            cnt_ff <= cnt_ff - 8'h01;
        end
        S_RREC: begin
          if (cnt_ff <= 8'h01)
            state_ff <= S_IDLE;
          else
            cnt_ff <= cnt_ff - 8'h01;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // flash_host

// ===== rtl/flash_host_regs.vh
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH
`define CLK_PERIOD_NS      20
`define RANDOM_ACCESS_NS   110
`define IN_PAGE_ACCESS_NS  30
`define WRITE_PULSE_NS     60
`define WRITE_RECOVER_NS   40
`define RESET_PULSE_NS     500
`define RESET_RECOVER_NS   200
`define RANDOM_ACCESS_CYC  ((`RANDOM_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IN_PAGE_ACCESS_CYC ((`IN_PAGE_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC    ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_RECOVER_CYC  ((`WRITE_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_CYC    ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_RECOVER_CYC  ((`RESET_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W             22
`define DATA_W             16
`define PAGE_LSB           2
`define CMD_ADDR_UNLOCK1   22'h00_0555
`define CMD_ADDR_UNLOCK2   22'h00_02AA
`define CMD_DATA_UNLOCK1   16'h00AA
`define CMD_DATA_UNLOCK2   16'h0055
`define CMD_DATA_PROGRAM   16'h00A0
`define CMD_DATA_AUTOSEL   16'h0090
`define CMD_DATA_RESET     16'h00F0
`define OP_READ            3'h0
`define OP_WRITE           3'h1
`define OP_PROGRAM         3'h2
`define OP_AUTOSEL         3'h3
`define OP_RESET           3'h4
`define OP_EXIT            3'h5
`endif

// ===== sim/flash_host_sva.sv
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_host_sva #(parameter ADDR_W = 22) (
  // host side
  input wire              core_clk_i, nrst_i, req_valid_i, req_ready_o, rsp_valid_o, accel_i,
  input wire [2:0]        req_op_i,
  input wire [ADDR_W-1:0] req_addr_i,
  // flash pins
  input wire              flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o,
  input wire              flash_dq_oe_o, program_boost_level_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  reg  [ADDR_W-1:0] page_ff;
  reg               page_ok_ff;
  reg  [7:0]        low_cnt_ff;
  wire take = req_valid_i && req_ready_o;
  wire rd_take = take && req_op_i == `OP_READ;
  wire same_pg = page_ok_ff && page_ff == (req_addr_i >> `PAGE_LSB);
  // any non-read op closes the page
  always @(posedge core_clk_i) begin
    if (!nrst_i) page_ok_ff <= 1'b0;
    else if (take) page_ok_ff <= rd_take;
    if (take) page_ff <= req_addr_i >> `PAGE_LSB;
    low_cnt_ff <= flash_reset_n_o ? 8'h00 : low_cnt_ff + 8'h01;
  end
  sequence we_pulse_s; (!flash_we_n_o && flash_dq_oe_o) [*3] ##1 flash_we_n_o [*2]; endsequence
  sequence full_wait_s; ##1 !rsp_valid_o [*5] ##[1:3] rsp_valid_o; endsequence
  sequence page_wait_s; ##1 !rsp_valid_o ##[1:3] rsp_valid_o; endsequence
  chk_read_strobes: assert property (!flash_ce_n_o && !flash_oe_n_o |-> flash_we_n_o)
    else $error("read with write strobe low");
  chk_write_strobes: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o)
    else $error("bad write strobes");
  chk_bus_turn: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
    else $error("host drives data during read");
  chk_write_pulse: assert property ($fell(flash_we_n_o) |-> we_pulse_s)
    else $error("bad write pulse");
  chk_full_access: assert property (rd_take && !same_pg |-> full_wait_s)
    else $error("random read timing");
  chk_page_access: assert property (rd_take && same_pg |-> page_wait_s)
    else $error("page read timing");
  chk_reset_len: assert property ($rose(flash_reset_n_o) |-> low_cnt_ff >= `RESET_PULSE_CYC)
    else $error("reset pulse too short");
  chk_boost_quiet: assert property (program_boost_level_o |-> accel_i && flash_oe_n_o)
    else $error("boost outside program");
endmodule // flash_host_sva
bind flash_host flash_host_sva #(.ADDR_W(ADDR_W)) u_sva (.core_clk_i(core_clk_i),
  .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .accel_i(accel_i),
  .rsp_valid_o(rsp_valid_o), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
  .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_reset_n_o(flash_reset_n_o), .flash_dq_oe_o(flash_dq_oe_o),
  .program_boost_level_o(program_boost_level_o));

// ===== sim/flash_dev_model.sv
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_dev_model #(parameter [7:0] AUTOSEL_CODE = 8'h5A) ( // code value arbitrary
  input wire        clk_i, ce_n_i, oe_n_i, we_n_i, reset_n_i,
  input wire        protect_accel_pin_i, program_boost_level_i,
  input wire [21:0] addr_i,
  input wire [15:0] bus_i,
  output wire [15:0] dq_o
);
  reg [15:0] mem [0:63];
  reg [15:0] last, wd;
  reg [21:0] wa;
  reg [1:0]  cyc;
  reg        asel, prog, wq;
  integer    i;
  wire drive = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
  // upper byte is not defined in code mode; host must mask it
  wire [15:0] rd = asel ? {8'hC3, AUTOSEL_CODE} : mem[addr_i[5:0]];
  // released bus must not keep showing the old word
  assign #15 dq_o = drive ? rd : ~last;
  always @* if (drive) last = rd;
  initial begin
    for (i = 0; i < 64; i = i + 1) mem[i] = 16'hC300 + i[15:0];
    {last, cyc, asel, prog} = 20'h0_0000;
  end
  // mid-cycle capture avoids racing the strobe release
  always @(negedge clk_i) if (!we_n_i) {wq, wa, wd} = {!ce_n_i && oe_n_i, addr_i, bus_i};
  always @(negedge reset_n_i) {cyc, asel, prog} = 4'h0;
  always @(posedge we_n_i) if (wq && reset_n_i) begin
    if (prog) begin
      if (protect_accel_pin_i || wa[21:15] != 7'h00) mem[wa[5:0]] = wd;
      {prog, cyc} = 3'h0;
    end else if (wd == `CMD_DATA_UNLOCK1 && wa == `CMD_ADDR_UNLOCK1) cyc = 2'd1;
    else if (cyc == 2'd1 && wd == `CMD_DATA_UNLOCK2) cyc = 2'd2;
    else begin
      if (cyc == 2'd2 || program_boost_level_i) prog = wd == `CMD_DATA_PROGRAM;
      if (cyc == 2'd2 && wd == `CMD_DATA_AUTOSEL) asel = 1'b1;
      if (wd == `CMD_DATA_RESET) asel = 1'b0;
      cyc = 2'd0;
    end
  end
endmodule // flash_dev_model

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module tb_top;
  reg core_clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0, accel_i = 1'b0, protect_i = 1'b1;
  reg  [2:0]  req_op_i = 3'h0;
  reg  [21:0] req_addr_i = 22'h00_0000;
  reg  [15:0] req_data_i = 16'h0000, q;
  wire        ready, rsp_v, ce_n, oe_n, we_n, rst_n, pin, boost, dq_oe;
  wire [15:0] rsp_d, dq_host, dq_dev, bus;
  wire [21:0] addr;
  integer     err_count = 0, compares = 0, cycles = 0, we_cnt = 0, i;
  always #10 core_clk_i = ~core_clk_i;
  assign bus = dq_oe ? dq_host : dq_dev;
  flash_host DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i), .accel_i(accel_i),
    .protect_i(protect_i), .req_ready_o(ready), .rsp_valid_o(rsp_v), .rsp_data_o(rsp_d),
    .flash_addr_o(addr), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
    .flash_reset_n_o(rst_n), .protect_accel_pin_o(pin), .program_boost_level_o(boost),
    .flash_dq_i(bus), .flash_dq_o(dq_host), .flash_dq_oe_o(dq_oe));
  flash_dev_model u_dev (.clk_i(core_clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .reset_n_i(rst_n), .protect_accel_pin_i(pin), .program_boost_level_i(boost),
    .addr_i(addr), .bus_i(bus), .dq_o(dq_dev));
  always @(negedge we_n) we_cnt = we_cnt + 1;
  always @(posedge core_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      err_count = err_count + 1;
      results;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // one request, held for one cycle, then wait for idle
  task go(input [2:0] op, input [21:0] a, input [15:0] d);
    integer n;
    begin
      @(negedge core_clk_i);
      {req_valid_i, req_op_i, req_addr_i, req_data_i} = {1'b1, op, a, d};
      @(negedge core_clk_i);
      req_valid_i = 1'b0;
      q = 16'hxxxx;
      for (n = 0; n < 300 && ready !== 1'b1; n = n + 1) begin
        if (rsp_v === 1'b1) q = rsp_d;
        @(negedge core_clk_i);
      end
      if (rsp_v === 1'b1) q = rsp_d;
    end
  endtask
  // first read needs no command; 8..11 share a page, 12 opens a new one
  task t_page;
    for (i = 7; i < 13; i = i + 1) begin
      go(`OP_READ, i[21:0], 16'h0000);
      check(q, 16'hC300 + i[15:0]);
    end
  endtask
  task t_prog;
    begin
      we_cnt = 0;
      go(`OP_PROGRAM, 22'h00_0004, 16'hBEEF);
      check(we_cnt[15:0], 16'h0004);
      go(`OP_READ, 22'h00_0004, 16'h0000);
      check(q, 16'hBEEF);
      protect_i = 1'b0;
      go(`OP_PROGRAM, 22'h00_0007, 16'h1234);
      go(`OP_READ, 22'h00_0007, 16'h0000);
      check(q, 16'hC307);
      protect_i = 1'b1;
      accel_i = 1'b1;
      we_cnt = 0;
      go(`OP_PROGRAM, 22'h20_0009, 16'h0A5A);
      check(we_cnt[15:0], 16'h0002);
      accel_i = 1'b0;
      go(`OP_READ, 22'h20_0009, 16'h0000);
      check(q, 16'h0A5A);
    end
  endtask
  // leave code mode by exit sequence, single reset command, then reset pin
  task t_modes;
    for (i = 0; i < 3; i = i + 1) begin
      go(`OP_AUTOSEL, 22'h00_0000, 16'h0000);
      go(`OP_READ, 22'h00_0001, 16'h0000);
      check(q, 16'h005A);
      go(i == 0 ? `OP_EXIT : i == 1 ? `OP_WRITE : `OP_RESET, 22'h00_0000, `CMD_DATA_RESET);
      go(`OP_READ, 22'h00_0001, 16'h0000);
      check(q, 16'hC301);
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    nrst_i = 1'b1;
    t_page;
    t_prog;
    t_modes;
    results;
  end
endmodule // tb_top
